// ==== design/pmcc_defs.vh ====
// register map, field positions and reset values of the power mode clock control block
`ifndef PMCC_DEFS_VH
`define PMCC_DEFS_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PMCC_PWR_CTRL_IDX 8'h87
`define PMCC_PWR_CTRL_EXT_IDX 8'hb9
`define PMCC_ADDR_W 10

// ****************************************************************
// power_control fields
// ****************************************************************
`define PMCC_PC_REDUCED 0
`define PMCC_PC_STOP 1
`define PMCC_PC_SWITCHBACK 2
`define PMCC_PC_PROG_WE 4
`define PMCC_PC_BAUD_DBL 7
`define PMCC_PC_MASK 8'h97
`define PMCC_PC_RESET 8'h00

// ****************************************************************
// power_control_extended fields
// ****************************************************************
`define PMCC_PE_DIV_LSB 0
`define PMCC_PE_DIV_MSB 2
`define PMCC_PE_DEEP_FLAG 3
`define PMCC_PE_REG_A 4
`define PMCC_PE_QUICK_DIS 5
`define PMCC_PE_MASK 8'h3f
`define PMCC_PE_RESET 8'h00

// ****************************************************************
// divider select codes and their log2 divide ratios
// ****************************************************************
`define PMCC_DIV_SEL_RTC 3'h7
`define PMCC_DIV_SEL_ZERO 3'h0
`define PMCC_DIV_LOG2_ZERO 3'h6
`define PMCC_DIV_LOG2_MAX 6

// ****************************************************************
// power mode one-hot codes
// ****************************************************************
`define PMCC_ST_NORMAL 5'h01
`define PMCC_ST_REDUCED 5'h02
`define PMCC_ST_SLEEP_TMR 5'h04
`define PMCC_ST_DEEP_SLEEP 5'h08
`define PMCC_ST_RESET_EXIT 5'h10

`endif

// ==== design/pmcc_tick_div.v ====
// power-of-two tick divider used to pace the core clock enable
`timescale 1ns/10ps
module pmcc_tick_div #(
  parameter CNT_W = 6
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // control
  input wire run,
  input wire tick_in,
  input wire [2:0] div_log2,
  // result
  output reg tick_q
);

  reg [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] last;

  assign last = ({{(CNT_W-1){1'b0}}, 1'b1} << div_log2) - {{(CNT_W-1){1'b0}}, 1'b1};

  // compare with >= so a shrinking ratio never leaves the counter stranded above its end
  always @(posedge ref_clk)
  begin
    if (rst || !run)
    begin
      cnt_q <= {CNT_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (tick_in)
    begin
      if (cnt_q >= last)
      begin
        cnt_q <= {CNT_W{1'b0}};
        tick_q <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        tick_q <= 1'b0;
      end
    end
    else
    begin
      tick_q <= 1'b0;
    end
  end

endmodule // pmcc_tick_div

// ==== design/pmcc_power_ctrl.v ====
// power mode and core clock control with its avalon-mm register slave
//
// Behaviour
// - in reduced mode select 001..110 divides by 2..64 and 000 by 64; normal mode runs undivided
// - select 111 uses rtc, halved in reduced mode
// - stop freezes core clock and all peripherals; radio_wor_run_q still runs in timer mode
// - resume on reset, key, key interrupt, timer
// - armed sleep timer makes stop the timer mode
// - power_control bit layout, all reset zero
// - deep flag turns next stop into reset-exit
// - extended register quick discharge and regulator bits
// - reduced mode returns to normal on interrupt
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "pmcc_defs.vh"
module pmcc_power_ctrl #(
  parameter DIV_CNT_W = 6
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // avalon-mm slave
  input wire [`PMCC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [7:0] avs_writedata,
  output reg [7:0] avs_readdata,
  output reg avs_waitrequest,
  // wake-up and timing sources
  input wire rtc_tick,
  input wire wake_key,
  input wire key_interrupt,
  input wire sleep_timer_expired,
  input wire wake_on_receive_armed,
  input wire core_interrupt,
  // core and peripheral control
  output reg core_clk_en_q,
  output reg periph_run_q,
  output reg radio_wor_run_q,
  output reg low_voltage_reset_en_q,
  output reg key_reset_req_q,
  output reg [4:0] power_mode_q,
  // static function enables
  output reg program_write_enable_q,
  output reg serial_baud_double_q,
  output reg switchback_enable_q,
  output reg regulator_a_enable_q,
  output reg quick_discharge_q
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg [7:0] pwr_ctrl_q;
  reg [7:0] pwr_ctrl_d;
  reg [7:0] pwr_ext_q;
  reg [7:0] pwr_ext_d;
  reg [4:0] state_q;
  reg [4:0] state_d;

  wire [7:0] word_idx;
  wire word_aligned;
  wire hit_ctrl;
  wire hit_ext;
  wire bus_req;
  wire bus_go;

  assign word_idx = avs_address[`PMCC_ADDR_W-1:2];
  assign word_aligned = (avs_address[1:0] == 2'h0);
  assign hit_ctrl = word_aligned && (word_idx == `PMCC_PWR_CTRL_IDX);
  assign hit_ext = word_aligned && (word_idx == `PMCC_PWR_CTRL_EXT_IDX);
  assign bus_req = avs_read || avs_write;
  // the request completes on the edge where the master sees waitrequest low
  assign bus_go = bus_req && !avs_waitrequest;

  // ****************************************************************
  // bus handshake: one wait cycle, then one ready cycle
  // ****************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 8'h00;
    end
    else
    begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        // unmapped or unaligned addresses read as zero
        if (hit_ctrl)
        begin
          avs_readdata <= pwr_ctrl_q & `PMCC_PC_MASK;
        end
        else if (hit_ext)
        begin
          avs_readdata <= pwr_ext_q & `PMCC_PE_MASK;
        end
        else
        begin
          avs_readdata <= 8'h00;
        end
      end
    end
  end

  // ****************************************************************
  // wake-up decode
  // ****************************************************************
  reg st_normal;
  reg st_reduced;
  reg st_sleep_tmr;
  reg st_deep;
  reg st_reset_exit;
  reg wake_accept;

  always @*
  begin
    st_normal = (state_q == `PMCC_ST_NORMAL);
    st_reduced = (state_q == `PMCC_ST_REDUCED);
    st_sleep_tmr = (state_q == `PMCC_ST_SLEEP_TMR);
    st_deep = (state_q == `PMCC_ST_DEEP_SLEEP);
    st_reset_exit = (state_q == `PMCC_ST_RESET_EXIT);
    // the sleep timer only counts while the radio is kept under its control
    wake_accept = ((st_sleep_tmr || st_deep) && (wake_key || key_interrupt)) ||
                  (st_sleep_tmr && sleep_timer_expired);
  end

  // ****************************************************************
  // register write and hardware updates
  // ****************************************************************
  always @*
  begin
    pwr_ctrl_d = pwr_ctrl_q;
    pwr_ext_d = pwr_ext_q;
    if (bus_go && avs_write && hit_ctrl)
    begin
      pwr_ctrl_d = avs_writedata & `PMCC_PC_MASK;
    end
    if (bus_go && avs_write && hit_ext)
    begin
      pwr_ext_d = avs_writedata & `PMCC_PE_MASK;
    end
    // the hardware clears are applied last so they win over a racing write
    if (wake_accept)
    begin
      pwr_ctrl_d[`PMCC_PC_STOP] = 1'b0;
    end
    if (st_reduced && core_interrupt && pwr_ctrl_q[`PMCC_PC_SWITCHBACK])
    begin
      pwr_ctrl_d[`PMCC_PC_REDUCED] = 1'b0;
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pwr_ctrl_q <= `PMCC_PC_RESET;
      pwr_ext_q <= `PMCC_PE_RESET;
    end
    else
    begin
      pwr_ctrl_q <= pwr_ctrl_d;
      pwr_ext_q <= pwr_ext_d;
    end
  end

  // ****************************************************************
  // power mode state machine
  // ****************************************************************
  // firmware is expected to pass through normal between reduced and stop;
  // a stop request seen in reduced mode is held until reduced is cleared
  always @*
  begin
    case (state_q)
      `PMCC_ST_NORMAL:
      begin
        if (pwr_ctrl_q[`PMCC_PC_STOP])
        begin
          if (pwr_ext_q[`PMCC_PE_DEEP_FLAG])
          begin
            state_d = `PMCC_ST_RESET_EXIT;
          end
          else if (wake_on_receive_armed)
          begin
            state_d = `PMCC_ST_SLEEP_TMR;
          end
          else
          begin
            state_d = `PMCC_ST_DEEP_SLEEP;
          end
        end
        else if (pwr_ctrl_q[`PMCC_PC_REDUCED])
        begin
          state_d = `PMCC_ST_REDUCED;
        end
        else
        begin
          state_d = `PMCC_ST_NORMAL;
        end
      end
      `PMCC_ST_REDUCED:
      begin
        // leaving reduced mode only ever goes to normal, never straight to stop
        if (!pwr_ctrl_q[`PMCC_PC_REDUCED])
        begin
          state_d = `PMCC_ST_NORMAL;
        end
        else
        begin
          state_d = `PMCC_ST_REDUCED;
        end
      end
      `PMCC_ST_SLEEP_TMR, `PMCC_ST_DEEP_SLEEP:
      begin
        // stop bit is cleared at the same edge, so wake lands in normal
        if (wake_accept)
        begin
          state_d = `PMCC_ST_NORMAL;
        end
        else
        begin
          state_d = state_q;
        end
      end
      `PMCC_ST_RESET_EXIT:
      begin
        // only a reset leaves this mode; the key raises a reset request
        state_d = `PMCC_ST_RESET_EXIT;
      end
      default:
      begin
        state_d = `PMCC_ST_NORMAL;
      end
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= `PMCC_ST_NORMAL;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // core clock pacing
  // ****************************************************************
  reg [2:0] div_log2;
  reg div_tick_src;
  reg div_run;
  wire [2:0] div_sel;
  wire div_tick;

  assign div_sel = pwr_ext_q[`PMCC_PE_DIV_MSB:`PMCC_PE_DIV_LSB];

  always @*
  begin
    div_run = st_normal || st_reduced;
    if (div_sel == `PMCC_DIV_SEL_RTC)
    begin
      // rtc directly in normal mode, rtc halved in reduced mode
      div_tick_src = rtc_tick;
      div_log2 = st_reduced ? 3'h1 : 3'h0;
    end
    else if (st_reduced)
    begin
      div_tick_src = 1'b1;
      if (div_sel == `PMCC_DIV_SEL_ZERO)
      begin
        div_log2 = `PMCC_DIV_LOG2_ZERO;
      end
      else
      begin
        div_log2 = div_sel;
      end
    end
    else
    begin
      div_tick_src = 1'b1;
      div_log2 = 3'h0;
    end
  end

  pmcc_tick_div #(
    .CNT_W(DIV_CNT_W)
  ) u_core_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(div_run),
    .tick_in(div_tick_src),
    .div_log2(div_log2),
    .tick_q(div_tick)
  );

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      core_clk_en_q <= 1'b0;
      periph_run_q <= 1'b1;
      radio_wor_run_q <= 1'b0;
      low_voltage_reset_en_q <= 1'b0;
      key_reset_req_q <= 1'b0;
      power_mode_q <= `PMCC_ST_NORMAL;
      program_write_enable_q <= 1'b0;
      serial_baud_double_q <= 1'b0;
      switchback_enable_q <= 1'b0;
      regulator_a_enable_q <= 1'b0;
      quick_discharge_q <= 1'b0;
    end
    else
    begin
      // any stop mode freezes the core and every peripheral but the radio wake-on-receive, which runs in timer mode
      core_clk_en_q <= div_run && div_tick;
      periph_run_q <= st_normal || st_reduced;
      radio_wor_run_q <= st_sleep_tmr;
      low_voltage_reset_en_q <= st_reset_exit;
      key_reset_req_q <= st_reset_exit && wake_key;
      power_mode_q <= state_q;
      program_write_enable_q <= pwr_ctrl_q[`PMCC_PC_PROG_WE];
      serial_baud_double_q <= pwr_ctrl_q[`PMCC_PC_BAUD_DBL];
      switchback_enable_q <= pwr_ctrl_q[`PMCC_PC_SWITCHBACK];
      regulator_a_enable_q <= pwr_ext_q[`PMCC_PE_REG_A];
      quick_discharge_q <= pwr_ext_q[`PMCC_PE_QUICK_DIS];
    end
  end

endmodule // pmcc_power_ctrl

// ==== dv/pmcc_checker.sv ====
// assertion checker bound to the power mode clock control block
`timescale 1ns/10ps
module pmcc_checker (
  // clock and reset
  input logic ref_clk,
  input logic rst,
  // bus and wake inputs
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic wake_key,
  input logic key_interrupt,
  // mode outputs
  input logic core_clk_en_q,
  input logic periph_run_q,
  input logic radio_wor_run_q,
  input logic low_voltage_reset_en_q,
  input logic [4:0] power_mode_q
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire stopped = |power_mode_q[4:2];
  chk_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("bus request left unanswered");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_stop_periph: assert property (stopped |-> !periph_run_q)
    else $error("peripherals run while stopped");
  chk_stop_clock: assert property (stopped [*2] |-> !core_clk_en_q)
    else $error("core clock enabled while stopped");
  chk_wor_run: assert property (radio_wor_run_q == (power_mode_q == 5'h04))
    else $error("radio run flag disagrees with mode");
  chk_exit_hold: assert property (power_mode_q == 5'h10 |=> power_mode_q == 5'h10 && low_voltage_reset_en_q)
    else $error("reset-exit mode left without reset");
  chk_key_wake: assert property (power_mode_q == 5'h04 && wake_key |-> ##[1:3] periph_run_q)
    else $error("key did not wake the device");
  chk_timer_ignore: assert property ((power_mode_q == 5'h08 && !wake_key && !key_interrupt) [*2]
    |=> power_mode_q == 5'h08)
    else $error("deep stop left without a key event");
endmodule // pmcc_checker

bind pmcc_power_ctrl pmcc_checker chk_u (.ref_clk(ref_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .wake_key(wake_key),
  .key_interrupt(key_interrupt), .core_clk_en_q(core_clk_en_q), .periph_run_q(periph_run_q),
  .radio_wor_run_q(radio_wor_run_q), .low_voltage_reset_en_q(low_voltage_reset_en_q),
  .power_mode_q(power_mode_q));

// ==== dv/power_mode_clock_control_test.sv ====
// self-checking testbench of the power mode clock control block
`timescale 1ns/10ps
`include "pmcc_defs.vh"
module power_mode_clock_control_test;
  localparam [9:0] PC = {`PMCC_PWR_CTRL_IDX, 2'b00};
  localparam [9:0] PE = {`PMCC_PWR_CTRL_EXT_IDX, 2'b00};
  logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, rtc_tick = 0, core_interrupt = 0;
  logic wake_key = 0, key_interrupt = 0, sleep_timer_expired = 0, wake_on_receive_armed = 0;
  logic [9:0] avs_address = 0;
  logic [7:0] avs_writedata = 0, rd, k, avs_readdata;
  logic avs_waitrequest, core_clk_en_q, periph_run_q, radio_wor_run_q, low_voltage_reset_en_q;
  logic key_reset_req_q, program_write_enable_q, serial_baud_double_q, switchback_enable_q;
  logic regulator_a_enable_q, quick_discharge_q;
  logic [4:0] power_mode_q;
  int miscompares = 0, checks_done = 0, pc_m, pe_m, n, g, rc = 0;

  pmcc_power_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rtc_tick(rtc_tick),
    .wake_key(wake_key), .key_interrupt(key_interrupt), .sleep_timer_expired(sleep_timer_expired),
    .wake_on_receive_armed(wake_on_receive_armed), .core_interrupt(core_interrupt),
    .core_clk_en_q(core_clk_en_q), .periph_run_q(periph_run_q), .radio_wor_run_q(radio_wor_run_q),
    .low_voltage_reset_en_q(low_voltage_reset_en_q), .key_reset_req_q(key_reset_req_q),
    .power_mode_q(power_mode_q), .program_write_enable_q(program_write_enable_q),
    .serial_baud_double_q(serial_baud_double_q), .switchback_enable_q(switchback_enable_q),
    .regulator_a_enable_q(regulator_a_enable_q), .quick_discharge_q(quick_discharge_q));

  // ****************************************
  // clock, slow tick and bus tasks
  // ****************************************
  always #10 ref_clk = ~ref_clk;
  // slow tick every five cycles stands in for the real-time clock
  always @(posedge ref_clk)
  begin
    rc <= (rc == 4) ? 0 : rc + 1;
    rtc_tick <= (rc == 4);
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (avs_waitrequest !== 1'b0)
    begin
      miscompares++;
      $display("unexpected bus answer timeout expected 0 seen 1");
      close_out;
    end
  endtask

  task rdchk(input logic [9:0] a, input logic [7:0] e, input string nm);
    bus(0, a, 0);
    chk(nm, e, rd);
  endtask

  // the first intervals after a mode change may be short, so only the last one is kept
  task gap;
    repeat (5)
    begin
      g = 0;
      do
      begin
        @(posedge ref_clk);
        g++;
      end while (core_clk_en_q !== 1'b1 && g < 300);
      if (g >= 300)
      begin
        miscompares++;
        $display("unexpected clock enable timeout expected 1 seen 0");
        close_out;
      end
    end
  endtask

  task pulse(input logic [2:0] w);
    @(posedge ref_clk);
    {sleep_timer_expired, key_interrupt, wake_key} <= w;
    @(posedge ref_clk);
    {sleep_timer_expired, key_interrupt, wake_key} <= 3'b000;
    repeat (3) @(posedge ref_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'h64471280));
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    rdchk(PC, 8'h00, "pc reset");
    rdchk(PE, 8'h00, "pe reset");
    repeat (4)
    begin
      pc_m = $urandom & 8'hfc;
      pe_m = $urandom & 8'hf7;
      bus(1, PC, pc_m);
      bus(1, PE, pe_m);
      rdchk(PC, pc_m & 8'h97, "pc");
      rdchk(PE, pe_m & 8'h3f, "pe");
      chk("enables", {pc_m[4], pc_m[7], pc_m[2], pe_m[4], pe_m[5]}, {program_write_enable_q,
        serial_baud_double_q, switchback_enable_q, regulator_a_enable_q, quick_discharge_q});
    end
    bus(1, 10'h004, 8'hff);
    rdchk(10'h004, 8'h00, "unmapped");
    rdchk(PC + 10'h1, 8'h00, "unaligned");
    rdchk(PC, pc_m & 8'h97, "pc kept");
    bus(1, PC, 8'h00);
    for (int s = 0; s < 8; s++)
    begin
      bus(1, PE, s[7:0]);
      gap;
      chk("normal gap", (s == 7) ? 8'd5 : 8'd1, g[7:0]);
      bus(1, PC, 8'h01);
      gap;
      chk("reduced gap", (s == 7) ? 8'd10 : (s == 0) ? 8'd64 : 8'd1 << s, g[7:0]);
      bus(1, PC, 8'h00);
    end
    for (int c = 0; c < 4; c++)
    begin
      wake_on_receive_armed <= (c != 1);
      bus(1, PE, (c == 3) ? 8'h08 : 8'h00);
      if (c == 2)
      begin
        // firmware leaves reduced mode through normal before it asks for stop
        bus(1, PC, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk("reduced first", 8'h02, power_mode_q);
        bus(1, PC, 8'h00);
      end
      bus(1, PC, 8'h02);
      repeat (3) @(posedge ref_clk);
      chk("stop mode", (c == 3) ? 8'h10 : (c == 1) ? 8'h08 : 8'h04, power_mode_q);
      chk("stop run", (c == 3) ? 8'h01 : (c == 1) ? 8'h00 : 8'h02,
        {periph_run_q, radio_wor_run_q, low_voltage_reset_en_q});
      k = 0;
      repeat (8)
      begin
        @(posedge ref_clk);
        k = k + core_clk_en_q;
      end
      chk("frozen clock", 8'h00, k);
      if (c == 1)
        pulse(3'b100);
      chk("still stopped", (c == 3) ? 8'h10 : (c == 1) ? 8'h08 : 8'h04, power_mode_q);
      if (c < 3)
      begin
        pulse((c == 0) ? 3'b100 : (c == 1) ? 3'b010 : 3'b001);
        chk("woken", 8'h01, power_mode_q);
        chk("periph back", 8'h01, periph_run_q);
        rdchk(PC, 8'h00, "stop cleared");
      end
      else
      begin
        wake_key <= 1;
        repeat (3) @(posedge ref_clk);
        chk("key reset", 8'h01, key_reset_req_q);
        wake_key <= 0;
        rst <= 1;
        repeat (8) @(posedge ref_clk);
        rst <= 0;
        rdchk(PE, 8'h00, "pe second reset");
      end
    end
    bus(1, PC, 8'h05);
    repeat (3) @(posedge ref_clk);
    chk("reduced", 8'h02, power_mode_q);
    @(posedge ref_clk);
    core_interrupt <= 1;
    @(posedge ref_clk);
    core_interrupt <= 0;
    repeat (3) @(posedge ref_clk);
    chk("switchback", 8'h01, power_mode_q);
    rdchk(PC, 8'h04, "reduced cleared");
    close_out;
  end
endmodule // power_mode_clock_control_test
